/* File: rtl/cfp_defines.svh */
// Timing counts and reset values for the converter fault protection block.
// Assumes a 200 MHz clock; include by bare name.
`ifndef CFP_DEFINES_SVH
`define CFP_DEFINES_SVH
`define CFP_CLK_MHZ 200
`define CFP_HICCUP_MS 130
`define CFP_HICCUP_CYC (`CFP_HICCUP_MS * 1000 * `CFP_CLK_MHZ)
`define CFP_MS_CYC (1000 * `CFP_CLK_MHZ)
`define CFP_PG_DLY_MAX_MS 150
`define CFP_TW_SET_C 120
`define CFP_TW_CLR_C 117
`define CFP_OT_SET_C 130
`define CFP_TRK_MV 250
`define CFP_OV_MIN_MV 500
`define CFP_OV_MARGIN_MV 250
`define CFP_FLAGS_RST 6'h3f
`endif

/* File: rtl/cfp_limits.sv */
// Computes protection thresholds in millivolts from the present setpoint.
// Assumes setpoint in mV; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defines.svh"
module cfp_limits (
    // Setpoint and selections.
    input wire logic [15:0] setpoint_mv,
    input wire logic pg_hi_sel,
    input wire logic pg_lo_sel,
    input wire logic [4:0] ov_pct_extra,
    // Thresholds.
    output logic [15:0] pg_hi_mv,
    output logic [15:0] pg_lo_mv,
    output logic [15:0] ov_mv
);
    logic [23:0] hi_w, lo_w, ov_w;
    logic [15:0] ov_raw, ov_floor;
    logic [4:0] ov_ext;
    always_comb begin
        hi_w = 24'(setpoint_mv) * (pg_hi_sel ? 24'd110 : 24'd105) / 24'd100;
        lo_w = 24'(setpoint_mv) * (pg_lo_sel ? 24'd95 : 24'd90) / 24'd100;
        ov_ext = (ov_pct_extra > 5'd20) ? 5'd20 : ov_pct_extra;
        ov_w = 24'(setpoint_mv) * (24'd110 + 24'(ov_ext)) / 24'd100;
        pg_hi_mv = hi_w[15:0];
        pg_lo_mv = lo_w[15:0];
        ov_raw = ov_w[15:0];
        ov_floor = setpoint_mv + 16'(`CFP_OV_MARGIN_MV);
        if (ov_raw < ov_floor) begin
            ov_raw = ov_floor;
        end
        if (ov_raw < 16'(`CFP_OV_MIN_MV)) begin
            ov_raw = 16'(`CFP_OV_MIN_MV);
        end
        ov_mv = ov_raw;
    end
endmodule // cfp_limits
`default_nettype wire

/* File: rtl/cfp_pkg.sv */
// Types shared by the converter fault protection block.
// No assumptions beyond a SystemVerilog tool.
package cfp_pkg;
    typedef enum logic [1:0] {CFP_OFF_NONE, CFP_OFF_SEQ, CFP_OFF_CRIT, CFP_OFF_EMERG} cfp_off_t;
    typedef enum {CFP_ST_OFF, CFP_ST_RAMP, CFP_ST_STEADY, CFP_ST_DOWN, CFP_ST_WAIT} cfp_state_t;
endpackage

/* File: rtl/cfp_protect.sv */
// Protection supervisor of a step-down converter: warnings, faults, error.
// Assumes digitised voltage, current and temperature inputs synchronous to clk.
// Operation
// - Warnings only indicate, never shut down.
// - Above 120 C set thermal warning.
// - Clear thermal warning below 117 C.
// - Power good low outside selectable window.
// - Check at steady state; release after delay.
// - Window scales with margined setpoint.
// - Warning pulls pin low, flag zero.
// - External low on pin is warning.
// - Power good drop on command or ramp.
// - Overcurrent above prebias: flag, critical off.
// - Overcurrent temperature compensation can be disabled.
// - Steady undervoltage without overcurrent: sequenced off.
// - Above 130 C: heat fault, sequenced off.
// - Non-latching heat restarts below 120 C.
// - Ramp deviation over 250 mV: critical off.
// - Ramp deviation check can be disabled.
// - Ramp check stops at power good.
// - Overvoltage above prebias: emergency off.
// - Overvoltage limit 110-130%, clamped minimums.
// - Latching and propagation set per protection.
// - Non-latching retries every 130 ms.
// - Latched stays off until clear conditions.
// - Sequenced off follows ramp-down settings.
// - Propagating fault pulls shared line low.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_defines.svh"
module cfp_protect #(
    parameter int HICCUP_CYC = `CFP_HICCUP_CYC,
    parameter int MS_CYC = `CFP_MS_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Measurements.
    input wire logic [15:0] vout_mv,
    input wire logic [15:0] prebias_mv,
    input wire logic [15:0] setpoint_mv,
    input wire logic [15:0] ramp_target_mv,
    input wire logic [7:0] temp_c,
    input wire logic iout_over_comp,
    input wire logic iout_over_raw,
    // Sequencer handshake.
    input wire logic turn_on_cmd,
    input wire logic ramp_done,
    input wire logic down_done,
    input wire logic margin_active,
    // Configuration.
    input wire logic current_limit_cfg_tc_en,
    input wire logic pg_hi_sel,
    input wire logic pg_lo_sel,
    input wire logic [4:0] ov_pct_extra,
    input wire logic [7:0] pg_delay_ms,
    input wire logic pg_at_ramp,
    input wire logic [5:0] fault_option_cfg_latch,
    input wire logic [5:0] fault_option_cfg_prop,
    input wire logic trk_en,
    input wire logic ot_crit,
    input wire logic uv_crit,
    input wire logic ov_emerg,
    // Status clear, one bit per flag.
    input wire logic [5:0] flag_clr,
    // Power good pin.
    input wire logic power_good_signal_i,
    output logic power_good_signal_o,
    output logic power_good_signal_oe,
    // Shared fault line.
    output logic fault_line_o,
    output logic fault_line_oe,
    // Power stage and status.
    output logic run,
    output logic ramp_down_req,
    output logic high_side_off,
    output logic low_side_on,
    output cfp_pkg::cfp_off_t off_style,
    output logic [5:0] protection_flag_reg,
    output logic thermal_warning_flag,
    output logic thermal_warning_alias_flag
);
    import cfp_pkg::*;

    // Flag order: 0 power good, 1 overcurrent, 2 low voltage, 3 heat, 4 ramp, 5 high voltage.
    localparam int FPG = 0, FOC = 1, FUV = 2, FOT = 3, FTR = 4, FOV = 5;

    cfp_state_t state_r;
    logic tw_r, pg_ok_r, pg_rel_r, trk_arm_r, oc_now, uv_now, ot_now, tr_now, ov_now, pg_in_win;
    logic [15:0] pg_hi_mv, pg_lo_mv, ov_mv, diff_mv;
    logic [5:0] trig, cause_r, flags_r;
    logic latched_r, cmd_prev_r;
    cfp_off_t style_nxt;
    logic hic_load, hic_done, hic_busy, pgd_load, pgd_done, pgd_busy;
    logic [31:0] pgd_count;

    cfp_limits u_limits (
        .setpoint_mv(setpoint_mv),
        .pg_hi_sel(pg_hi_sel),
        .pg_lo_sel(pg_lo_sel),
        .ov_pct_extra(ov_pct_extra),
        .pg_hi_mv(pg_hi_mv),
        .pg_lo_mv(pg_lo_mv),
        .ov_mv(ov_mv)
    );

    // Thermal warning with hysteresis; indication only.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tw_r <= 1'b0;
        end else if (temp_c > 8'(`CFP_TW_SET_C)) begin
            tw_r <= 1'b1;
        end else if (temp_c < 8'(`CFP_TW_CLR_C)) begin
            tw_r <= 1'b0;
        end
    end
    assign thermal_warning_flag = ~tw_r;
    assign thermal_warning_alias_flag = ~tw_r;

    // Fault detectors.
    always_comb begin
        diff_mv = (vout_mv > ramp_target_mv) ? vout_mv - ramp_target_mv : ramp_target_mv - vout_mv;
        oc_now = (vout_mv > prebias_mv) && (current_limit_cfg_tc_en ? iout_over_comp : iout_over_raw);
        uv_now = (state_r == CFP_ST_STEADY) && (vout_mv < pg_lo_mv) && !oc_now;
        ot_now = temp_c > 8'(`CFP_OT_SET_C);
        tr_now = trk_en && trk_arm_r && (state_r == CFP_ST_RAMP) && (diff_mv > 16'(`CFP_TRK_MV));
        ov_now = (vout_mv > prebias_mv) && (vout_mv > ov_mv);
        pg_in_win = (vout_mv >= pg_lo_mv) && (vout_mv <= pg_hi_mv);
        trig = {ov_now, tr_now, ot_now, uv_now, oc_now, 1'b0};
    end

    // Most severe style among simultaneous triggers.
    always_comb begin
        style_nxt = CFP_OFF_NONE;
        if (trig[FUV] || trig[FOT]) begin
            style_nxt = ((trig[FUV] && uv_crit) || (trig[FOT] && ot_crit)) ? CFP_OFF_CRIT : CFP_OFF_SEQ;
        end
        if (trig[FOC] || trig[FTR]) begin
            style_nxt = CFP_OFF_CRIT;
        end
        if (trig[FOV]) begin
            style_nxt = ov_emerg ? CFP_OFF_EMERG : CFP_OFF_CRIT;
        end
    end

    // Tracking arm: only during the first ramp, dropped at power good.
    always_ff @(posedge clk) begin
        if (sys_rst || state_r == CFP_ST_OFF || state_r == CFP_ST_WAIT) begin
            trk_arm_r <= 1'b1;
        end else if (pg_ok_r || margin_active) begin
            trk_arm_r <= 1'b0;
        end
    end

    // Sequencing state and turn-off style.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= CFP_ST_OFF;
            off_style <= CFP_OFF_NONE;
            cause_r <= 6'h00;
            latched_r <= 1'b0;
            cmd_prev_r <= 1'b0;
        end else begin
            cmd_prev_r <= turn_on_cmd;
            if ((state_r == CFP_ST_RAMP || state_r == CFP_ST_STEADY) && trig != 6'h00) begin
                cause_r <= trig;
                latched_r <= |(trig & fault_option_cfg_latch);
                off_style <= style_nxt;
                state_r <= (style_nxt == CFP_OFF_SEQ) ? CFP_ST_DOWN : CFP_ST_WAIT;
            end else begin
                unique case (state_r)
                    CFP_ST_OFF: begin
                        off_style <= CFP_OFF_NONE;
                        if (turn_on_cmd && !ot_now) begin
                            state_r <= CFP_ST_RAMP;
                        end
                    end
                    CFP_ST_RAMP: begin
                        if (!turn_on_cmd) begin
                            state_r <= CFP_ST_DOWN;
                        end else if (ramp_done) begin
                            state_r <= CFP_ST_STEADY;
                        end
                    end
                    CFP_ST_STEADY: begin
                        if (!turn_on_cmd) begin
                            state_r <= CFP_ST_DOWN;
                        end
                    end
                    CFP_ST_DOWN: begin
                        if (down_done) begin
                            state_r <= (cause_r != 6'h00) ? CFP_ST_WAIT : CFP_ST_OFF;
                        end
                    end
                    CFP_ST_WAIT: begin
                        if (latched_r && ((cause_r & flag_clr) != 6'h00 || (turn_on_cmd && !cmd_prev_r))) begin
                            latched_r <= 1'b0;
                        end
                        if (!turn_on_cmd) begin
                            latched_r <= 1'b0;
                        end
                        if (hic_done || (!hic_busy && !hic_load)) begin
                            if (cause_r[FOT] && !latched_r && temp_c < 8'(`CFP_TW_SET_C)) begin
                                state_r <= CFP_ST_OFF;
                                cause_r <= 6'h00;
                            end else if (!latched_r && (cause_r & trig) == 6'h00 && !cause_r[FOT]) begin
                                state_r <= CFP_ST_OFF;
                                cause_r <= 6'h00;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Hiccup timer runs from each fault entry.
    assign hic_load = (state_r == CFP_ST_RAMP || state_r == CFP_ST_STEADY) && trig != 6'h00;
    cfp_timer #(.W(32)) u_hiccup (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(hic_load),
        .count(32'(HICCUP_CYC)),
        .busy(hic_busy),
        .done(hic_done)
    );

    // Power good release delay after steady state.
    assign pgd_load = (state_r == CFP_ST_RAMP) && ramp_done && turn_on_cmd && trig == 6'h00;
    assign pgd_count = 32'(pg_delay_ms > 8'(`CFP_PG_DLY_MAX_MS) ? 8'(`CFP_PG_DLY_MAX_MS) : pg_delay_ms) * 32'(MS_CYC);
    cfp_timer #(.W(32)) u_pg_delay (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(pgd_load),
        .count(pgd_count),
        .busy(pgd_busy),
        .done(pgd_done)
    );

    always_ff @(posedge clk) begin
        if (sys_rst || state_r != CFP_ST_STEADY) begin
            pg_rel_r <= 1'b0;
        end else if (pgd_done || (!pgd_busy && !pgd_load)) begin
            pg_rel_r <= 1'b1;
        end
    end

    // Power good level; command-based drop when selected.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pg_ok_r <= 1'b0;
        end else begin
            pg_ok_r <= pg_rel_r && pg_in_win && (pg_at_ramp || turn_on_cmd);
        end
    end
    assign power_good_signal_o = 1'b0;
    assign power_good_signal_oe = ~pg_ok_r;

    // Status flags: zero on event, set beats clear.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_r <= `CFP_FLAGS_RST;
        end else begin
            flags_r <= (flags_r | flag_clr) & ~trig;
            flags_r[FPG] <= (pg_ok_r && power_good_signal_i) || state_r != CFP_ST_STEADY;
        end
    end
    assign protection_flag_reg = flags_r;

    // Power stage drive and shared fault line.
    assign run = (state_r == CFP_ST_RAMP) || (state_r == CFP_ST_STEADY);
    assign ramp_down_req = (state_r == CFP_ST_DOWN);
    assign high_side_off = !run || (state_r == CFP_ST_WAIT);
    assign low_side_on = (state_r == CFP_ST_WAIT) && (off_style == CFP_OFF_EMERG);
    assign fault_line_o = 1'b0;
    assign fault_line_oe = (state_r == CFP_ST_DOWN || state_r == CFP_ST_WAIT)
        && (cause_r & fault_option_cfg_prop) != 6'h00;

    thermal_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        temp_c > 8'd120 |=> !thermal_warning_flag) else $error("thermal warning not set");
    thermal_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !thermal_warning_flag && temp_c >= 8'd117 |=> !thermal_warning_flag) else $error("warning left early");
    oc_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        oc_now |=> !protection_flag_reg[1]) else $error("overcurrent flag not cleared");
    ov_emerg_a: assert property (@(posedge clk) disable iff (sys_rst)
        run && ov_now && ov_emerg |=> low_side_on && high_side_off) else $error("overvoltage not emergency");
    uv_seq_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == CFP_ST_STEADY && uv_now && !ot_now && !ov_now && !uv_crit |=> ramp_down_req)
        else $error("low voltage not sequenced");
    trk_crit_a: assert property (@(posedge clk) disable iff (sys_rst)
        tr_now && !ov_now |=> off_style == CFP_OFF_CRIT && !run) else $error("ramp fault not critical");
    pg_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == CFP_ST_STEADY && !power_good_signal_i |=> !protection_flag_reg[0])
        else $error("external low ignored");
    ov_clamp_a: assert property (@(posedge clk) disable iff (sys_rst)
        ov_mv >= 16'd500 && ov_mv >= setpoint_mv + 16'd250) else $error("overvoltage clamp broken");
    latch_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == CFP_ST_WAIT && latched_r && turn_on_cmd && flag_clr == 6'h00 && $past(turn_on_cmd)
        |=> state_r == CFP_ST_WAIT) else $error("latched fault restarted");
endmodule // cfp_protect
`default_nettype wire

/* File: rtl/cfp_timer.sv */
// Down counter that pulses done when a loaded count runs out.
// Assumes load and count are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cfp_timer #(
    parameter int W = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Control.
    input wire logic load,
    input wire logic [W-1:0] count,
    // Status.
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (load) begin
            cnt_r <= count;
            done <= (count == '0);
        end else begin
            done <= (cnt_r == W'(1));
            if (cnt_r != '0) begin
                cnt_r <= cnt_r - W'(1);
            end
        end
    end
    assign busy = (cnt_r != '0);
endmodule // cfp_timer
`default_nettype wire

/* File: test/cfp_mgr_model.sv */
// Model of the power manager and ramp sequencer on the far side of the block.
// Assumes one clock and a pulled-up power good wire.
`timescale 1ns/1ps
`default_nettype none
module cfp_mgr_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Bench controls.
    input wire logic allow_ramp,
    input wire logic ext_pg_low,
    input wire logic [5:0] clr_req,
    // Block side.
    input wire logic run,
    input wire logic ramp_down_req,
    input wire logic pg_oe,
    input wire logic pg_o,
    input wire logic [5:0] flags,
    output logic ramp_done_r,
    output logic down_done_r,
    output logic pg_i,
    output logic [5:0] flag_clr_r
);
    // The wire is low whenever any party pulls it.
    assign pg_i = ~((pg_oe & ~pg_o) | ext_pg_low);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ramp_done_r <= 1'b0;
            down_done_r <= 1'b0;
            flag_clr_r <= 6'h00;
        end else begin
            ramp_done_r <= run & allow_ramp & ~ramp_down_req;
            down_done_r <= ramp_down_req;
            flag_clr_r <= clr_req & ~flags;
        end
    end
endmodule // cfp_mgr_model
`default_nettype wire

/* File: test/converter_fault_protection_test.sv */
// Self-checking bench for the protection supervisor.
// Assumes cfp_pkg, cfp_protect and cfp_mgr_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module converter_fault_protection_test;
    import cfp_pkg::*;
    localparam int HC = 200;
    logic clk, sys_rst, iout_over_comp, iout_over_raw, turn_on_cmd, ramp_done, down_done, margin_active;
    logic current_limit_cfg_tc_en, pg_hi_sel, pg_lo_sel, pg_at_ramp, trk_en, ot_crit, uv_crit, ov_emerg;
    logic power_good_signal_i, power_good_signal_o, power_good_signal_oe, fault_line_o, fault_line_oe;
    logic run, ramp_down_req, high_side_off, low_side_on, thermal_warning_flag, thermal_warning_alias_flag;
    logic allow_ramp, ext_pg_low;
    logic [15:0] vout_mv, prebias_mv, setpoint_mv, ramp_target_mv;
    logic [7:0] temp_c, pg_delay_ms;
    logic [4:0] ov_pct_extra;
    logic [5:0] fault_option_cfg_latch, fault_option_cfg_prop, flag_clr, protection_flag_reg, clr_req;
    cfp_off_t off_style;
    logic [31:0] seed, r;
    int bad_count, compares, k, sp, v;
    int pcts [6] = '{97, 100, 103, 107, 108, 112};
    cfp_protect #(.HICCUP_CYC(HC), .MS_CYC(10)) DUT (.*);
    cfp_mgr_model model (.clk(clk), .sys_rst(sys_rst), .allow_ramp(allow_ramp), .ext_pg_low(ext_pg_low),
        .clr_req(clr_req), .run(run), .ramp_down_req(ramp_down_req), .pg_oe(power_good_signal_oe),
        .pg_o(power_good_signal_o), .flags(protection_flag_reg), .ramp_done_r(ramp_done),
        .down_done_r(down_done), .pg_i(power_good_signal_i), .flag_clr_r(flag_clr));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic in_win(input int s, input int x, input logic hs, input logic ls);
        return (x * 100 < s * (hs ? 110 : 105)) && (x * 100 > s * (ls ? 95 : 90));
    endfunction
    task results;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_run(input logic x, input int n);
        int i;
        for (i = 0; i < n && run !== x; i++) begin
            @(posedge clk);
            #1;
        end
        if (run !== x) begin
            bad_count++;
            $display("CHECK FAILED run wait expected %h seen %h", x, run);
            results();
        end
    endtask
    // Turns on, waits for the power good release and clears stale flags.
    task bring_up(input int n);
        int i;
        turn_on_cmd <= 1'b1;
        wait_run(1'b1, n);
        for (i = 0; i < 80 && power_good_signal_oe !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk("pg_delay", 1, i >= 20);
        chk("pg_oe", 0, power_good_signal_oe);
        clr_req <= 6'h3f;
        @(posedge clk);
        clr_req <= 6'h00;
    endtask
    initial begin
        seed = 32'd12;
        bad_count = 0;
        compares = 0;
        sys_rst = 1'b1;
        {iout_over_comp, iout_over_raw, turn_on_cmd, margin_active, pg_at_ramp, trk_en} = '0;
        {ot_crit, uv_crit, ext_pg_low, pg_lo_sel} = '0;
        {current_limit_cfg_tc_en, pg_hi_sel, ov_emerg, allow_ramp} = '1;
        {vout_mv, setpoint_mv, ramp_target_mv, prebias_mv} = {16'd1000, 16'd1000, 16'd1000, 16'd0};
        {temp_c, pg_delay_ms, ov_pct_extra} = {8'd25, 8'd2, 5'd20};
        {fault_option_cfg_latch, fault_option_cfg_prop, clr_req} = {6'h00, 6'h02, 6'h00};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        look(1);
        chk("flags", 6'h3f, protection_flag_reg);
        chk("warn", 3, {thermal_warning_flag, thermal_warning_alias_flag});
        chk("stage", 3'b010, {run, high_side_off, low_side_on});
        chk("style", CFP_OFF_NONE, off_style);
        chk("lines", 2'b10, {power_good_signal_oe, fault_line_oe});
        @(posedge clk);
        bring_up(10);
        @(posedge clk);
        temp_c <= 8'd121;
        look(3);
        chk("warn", 0, {thermal_warning_flag, thermal_warning_alias_flag});
        chk("run", 1, run);
        @(posedge clk);
        temp_c <= 8'd131;
        look(2);
        chk("heat", 0, protection_flag_reg[3]);
        chk("style", CFP_OFF_SEQ, off_style);
        chk("down", 1, ramp_down_req);
        @(posedge clk);
        temp_c <= 8'd119;
        bring_up(3 * HC);
        chk("warn", 0, {thermal_warning_flag, thermal_warning_alias_flag});
        @(posedge clk);
        temp_c <= 8'd116;
        look(3);
        chk("warn", 3, {thermal_warning_flag, thermal_warning_alias_flag});
        for (k = 0; k < 12; k++) begin
            r = rnd();
            sp = 900 + 100 * (r[1:0] % 3);
            v = sp * pcts[r[10:8] % 6] / 100;
            @(posedge clk);
            {setpoint_mv, ramp_target_mv, vout_mv} <= {16'(sp), 16'(sp), 16'(v)};
            {margin_active, pg_hi_sel, pg_lo_sel} <= r[6:4];
            look(30);
            chk("pg_flag", in_win(sp, v, r[5], r[4]), protection_flag_reg[0]);
            chk("pg_oe", !in_win(sp, v, r[5], r[4]), power_good_signal_oe);
        end
        @(posedge clk);
        {setpoint_mv, ramp_target_mv, vout_mv} <= {16'd1000, 16'd1000, 16'd1000};
        {pg_hi_sel, pg_lo_sel, margin_active} <= 3'b100;
        ext_pg_low <= 1'b1;
        look(3);
        chk("ext_pg", 0, protection_flag_reg[0]);
        @(posedge clk);
        ext_pg_low <= 1'b0;
        look(30);
        chk("ext_pg", 1, protection_flag_reg[0]);
        @(posedge clk);
        {prebias_mv, iout_over_comp} <= {16'd2000, 1'b1};
        look(3);
        chk("oc", 1, protection_flag_reg[1]);
        @(posedge clk);
        {prebias_mv, iout_over_comp, iout_over_raw} <= {16'd0, 1'b0, 1'b1};
        look(3);
        chk("oc", 1, protection_flag_reg[1]);
        @(posedge clk);
        current_limit_cfg_tc_en <= 1'b0;
        look(2);
        chk("oc", 0, protection_flag_reg[1]);
        chk("stage", 3'b010, {run, high_side_off, low_side_on});
        chk("style", CFP_OFF_CRIT, off_style);
        chk("fline", 2'b10, {fault_line_oe, fault_line_o});
        @(posedge clk);
        {current_limit_cfg_tc_en, iout_over_raw} <= 2'b10;
        bring_up(3 * HC);
        @(posedge clk);
        {trk_en, ramp_target_mv} <= {1'b1, 16'd1300};
        look(3);
        chk("trk", 1, protection_flag_reg[4]);
        @(posedge clk);
        {ramp_target_mv, turn_on_cmd, trk_en, allow_ramp} <= {16'd1000, 3'b000};
        look(3);
        chk("pg_oe", 1, power_good_signal_oe);
        wait_run(1'b0, 50);
        @(posedge clk);
        {turn_on_cmd, ramp_target_mv} <= {1'b1, 16'd1300};
        look(4);
        chk("trk", 1, protection_flag_reg[4]);
        @(posedge clk);
        trk_en <= 1'b1;
        look(2);
        chk("trk", 0, protection_flag_reg[4]);
        chk("style", CFP_OFF_CRIT, off_style);
        @(posedge clk);
        {ramp_target_mv, allow_ramp} <= {16'd1000, 1'b1};
        bring_up(3 * HC);
        @(posedge clk);
        vout_mv <= 16'd850;
        look(2);
        chk("uv", 0, protection_flag_reg[2]);
        chk("style", CFP_OFF_SEQ, off_style);
        @(posedge clk);
        {vout_mv, fault_option_cfg_latch, fault_option_cfg_prop} <= {16'd1000, 6'h20, 6'h00};
        bring_up(3 * HC);
        @(posedge clk);
        {vout_mv, iout_over_comp} <= {16'd1400, 1'b1};
        look(2);
        chk("ov_oc", 0, {protection_flag_reg[5], protection_flag_reg[1]});
        chk("stage", 3'b011, {run, high_side_off, low_side_on});
        chk("style", CFP_OFF_EMERG, off_style);
        chk("fline", 0, fault_line_oe);
        @(posedge clk);
        {vout_mv, iout_over_comp} <= {16'd1000, 1'b0};
        look(3 * HC);
        chk("latched", 0, run);
        @(posedge clk);
        clr_req <= 6'h20;
        @(posedge clk);
        clr_req <= 6'h00;
        bring_up(3 * HC);
        results();
    end
endmodule // converter_fault_protection_test
`default_nettype wire
